// file: verilog/bro_port.v
// BCD result readout port: request handshake, data hold and valid strobe
`include "bro_defs.vh"
module bro_port #(
  parameter DIGITS = 5,
  parameter TICK_CYC = `BRO_TICK_CYC
) (
  // Clock and reset
  input wire MCLK_I,
  input wire RST_I,
  // Measurement source
  input wire [4*DIGITS-1:0] MEAS_BCD_I,
  input wire MEAS_NEG_I,
  input wire MEAS_OVER_I,
  // Controller side, active low
  input wire REQ_N_I,
  input wire FREEZE_N_I,
  // Result lines
  output wire [4*DIGITS-1:0] BCD_O,
  output wire NEG_O,
  output wire OVER_O,
  output wire VALID_O
);
  wire tick;
  reg [1:0] st_ff;
  reg [1:0] nxt_st;
  reg [6:0] ms_ff;
  reg [6:0] nxt_ms;
  reg req_d_ff;
  reg [4*DIGITS-1:0] bcd_ff;
  reg neg_ff;
  reg over_ff;
  reg drive_ff;
  reg valid_ff;
  reg load;
  reg nxt_drive;
  reg nxt_valid;
  wire req = ~REQ_N_I; // R9
  wire freeze = ~FREEZE_N_I; // R9
  wire req_rise = req & ~req_d_ff;

  bro_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .tick_o(tick)
  );

  // ==========================================
  // Sequencer
  always @* begin
    nxt_st = st_ff;
    nxt_ms = ms_ff;
    load = 1'b0;
    nxt_drive = drive_ff;
    nxt_valid = valid_ff;
    case (st_ff)
      `BRO_ST_IDLE: begin
        if (req_rise) begin // R1
          nxt_st = `BRO_ST_SETUP;
          nxt_ms = 7'h0;
          load = 1'b1; // R2
          nxt_drive = 1'b1;
        end
      end
      `BRO_ST_SETUP: begin
        if (tick) begin
          nxt_ms = ms_ff + 7'h1;
          if (ms_ff == `BRO_SETUP_MS - 1) begin
            nxt_st = `BRO_ST_VALID; // R2
            nxt_ms = 7'h0;
            nxt_valid = 1'b1;
          end
        end
      end
      `BRO_ST_VALID: begin
        if (tick) begin
          nxt_ms = ms_ff + 7'h1;
          if (req && ms_ff == `BRO_PERIOD_MS - 1) begin
            // Refresh without blanking; freeze keeps the prior value
            nxt_ms = 7'h0;
            load = ~freeze; // R6 R7 R8
          end else if (!req && ms_ff >= `BRO_VALID_MS - 1) begin
            nxt_st = `BRO_ST_TAIL; // R4
            nxt_ms = 7'h0;
            nxt_valid = 1'b0;
          end
        end
      end
      `BRO_ST_TAIL: begin
        if (tick) begin
          nxt_ms = ms_ff + 7'h1;
          if (ms_ff == `BRO_RELEASE_MS - 1) begin
            nxt_st = `BRO_ST_IDLE; // R5
            nxt_drive = 1'b0;
          end
        end
      end
      default: begin
        nxt_st = `BRO_ST_IDLE;
      end
    endcase
  end

  always @(posedge MCLK_I) begin
    if (RST_I) begin
      st_ff <= `BRO_ST_IDLE;
      ms_ff <= 7'h0;
      req_d_ff <= 1'b0;
      bcd_ff <= {4*DIGITS{1'b0}};
      neg_ff <= 1'b0;
      over_ff <= 1'b0;
      drive_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ms_ff <= nxt_ms;
      req_d_ff <= req;
      drive_ff <= nxt_drive;
      valid_ff <= nxt_valid;
      // Captured only at load points: the request edge and each 64 ms refresh without freeze while strobe is on
      if (load) begin // R10
        bcd_ff <= MEAS_BCD_I;
        neg_ff <= MEAS_NEG_I;
        over_ff <= MEAS_OVER_I;
      end
    end
  end

  // Released lines read as zero
  genvar gi;
  generate
    for (gi = 0; gi < DIGITS; gi = gi + 1) begin : g_dig
      assign BCD_O[4*gi+3:4*gi] = drive_ff ? bcd_ff[4*gi+3:4*gi] : 4'h0; // R5
    end
  endgenerate
  assign NEG_O = drive_ff & neg_ff;
  assign OVER_O = drive_ff & over_ff;
  assign VALID_O = valid_ff; // R3
endmodule // bro_port

// file: verilog/bro_defs.vh
// Constants and timing for the BCD result readout port
// What this block does
// R1: Reader must assert request first; without request no new result is driven.
// R2: On request edge, data is placed, then valid strobe asserts about 30 ms later.
// R3: Reader samples data lines only after valid strobe turns on.
// R4: Single sample: valid strobe drops 40 ms after it rose.
// R5: Single sample: data lines released 16 ms after valid strobe drops.
// R6: While request stays asserted, a new value is output every 64 ms.
// R7: Freeze during changeover yields either the earlier or the later value.
// R8: Freeze during changeover never drives all data lines inactive between values.
// R9: Request and freeze inputs are active low.
// R10: While valid strobe is asserted, digits, sign and overrange change only at a 64 ms refresh.
`ifndef BRO_DEFS_VH
`define BRO_DEFS_VH
// ==========================================
// Timebase
`define BRO_CLK_HZ 125000000
`define BRO_TICK_NS 1000000
`define BRO_CLK_NS 8
`define BRO_TICK_CYC (`BRO_TICK_NS / `BRO_CLK_NS)
// ==========================================
// Timing in milliseconds
`define BRO_SETUP_MS 30
`define BRO_VALID_MS 40
`define BRO_RELEASE_MS 16
`define BRO_PERIOD_MS 64
// ==========================================
// States
`define BRO_ST_IDLE 2'h0
`define BRO_ST_SETUP 2'h1
`define BRO_ST_VALID 2'h2
`define BRO_ST_TAIL 2'h3
`endif

// file: verilog/bro_tick.v
// Millisecond tick generator for the BCD readout port
`include "bro_defs.vh"
module bro_tick #(
  parameter TICK_CYC = `BRO_TICK_CYC
) (
  input wire clk_i,
  input wire rst_i,
  output wire tick_o
);
  // Count wide enough for the full-speed 1 ms divider
  localparam [31:0] LAST_FULL = TICK_CYC - 1;
  reg [19:0] cnt_ff;
  wire [19:0] last = LAST_FULL[19:0];
  assign tick_o = (cnt_ff == last);
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 20'h0;
    end else if (tick_o) begin
      cnt_ff <= 20'h0;
    end else begin
      cnt_ff <= cnt_ff + 20'h1;
    end
  end
endmodule // bro_tick

// file: tb/bro_port_props.sv
// Checker for the readout port
module bro_port_props #(
  parameter int DIGITS = 5,
  parameter int TICK_CYC = 4
) (
  input wire MCLK_I,
  input wire RST_I,
  input wire REQ_N_I,
  input wire VALID_O,
  input wire [4*DIGITS-1:0] BCD_O
);
  localparam int SETUP_MS = 30;
  localparam int VALID_MS = 40;
  localparam int RELEASE_MS = 16;
  localparam int PERIOD_MS = 64;
  logic v_q = 1'b0;
  logic r_q = 1'b1;
  logic tail_ff = 1'b0;
  logic [4*DIGITS-1:0] b_q = '0;
  int hi_cnt = 0;
  int lo_cnt = 0;
  int req_cnt = 0;
  int chg_cnt = 0;
  // Cycle counters stand in for long delays, which scale with the tick
  always @(posedge MCLK_I) begin
    v_q <= VALID_O;
    r_q <= REQ_N_I;
    b_q <= BCD_O;
    hi_cnt <= VALID_O ? hi_cnt + 1 : 0;
    req_cnt <= (r_q && !REQ_N_I) ? 1 : req_cnt + 1;
    chg_cnt <= ((VALID_O && !v_q) || BCD_O != b_q) ? 1 : chg_cnt + 1;
    if (RST_I) begin
      tail_ff <= 1'b0;
      lo_cnt <= 0;
    end else if (v_q && !VALID_O) begin
      tail_ff <= 1'b1;
      lo_cnt <= 1;
    end else if (BCD_O == '0) begin
      tail_ff <= 1'b0;
    end else if (tail_ff) begin
      lo_cnt <= lo_cnt + 1;
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  AST_HOLD: assert property ($fell(VALID_O) |-> hi_cnt >= VALID_MS * TICK_CYC) else $error("short");
  AST_REL: assert property (tail_ff && BCD_O != '0 |-> lo_cnt < RELEASE_MS * TICK_CYC) else $error("held");
  AST_GAP: assert property (VALID_O && $past(VALID_O) && $past(BCD_O) != 0 |-> BCD_O != 0) else $error("blank");
  AST_SETUP: assert property ($rose(VALID_O) |-> req_cnt > (SETUP_MS - 1) * TICK_CYC &&
    req_cnt <= SETUP_MS * TICK_CYC + 1) else $error("setup time");
  AST_KEEP: assert property ($fell(VALID_O) |-> $past(REQ_N_I)) else $error("dropped under request");
  AST_STEADY: assert property (VALID_O && v_q && BCD_O != b_q |-> chg_cnt >= PERIOD_MS * TICK_CYC)
    else $error("data moved");
  cover property ($rose(VALID_O));
  cover property ($fell(VALID_O));
  cover property (VALID_O && !REQ_N_I);
endmodule // bro_port_props
bind bro_port bro_port_props #(.DIGITS(DIGITS), .TICK_CYC(TICK_CYC)) u_props (.MCLK_I(MCLK_I), .RST_I(RST_I),
  .REQ_N_I(REQ_N_I), .VALID_O(VALID_O), .BCD_O(BCD_O));

// file: tb/bro_reader.sv
// Controller model: requests and samples results
module bro_reader (
  input wire clk_i,
  input wire go_i,
  input wire valid_i,
  input wire [19:0] bcd_i,
  output logic req_n_o = 1'b1,
  output logic [19:0] got_o = 20'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk_i) req_n_o <= !go_i;
  // Takes data only once the strobe is on
  always @(posedge clk_i) if (valid_i) got_o <= bcd_i;
endmodule // bro_reader

// file: tb/bro_port_tb.sv
// Bench for the readout port
module bro_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, go = 0, frz_n = 1, neg = 0, ovi = 0, req_n, sgn, ovr, vld;
  logic [19:0] meas = 20'h12345, bcd, got;
  int num_errors = 0, checks_done = 0, n;
  always #4 clk = ~clk;
  bro_reader u_rd (.clk_i(clk), .go_i(go), .valid_i(vld), .bcd_i(bcd), .req_n_o(req_n), .got_o(got));
  bro_port #(.TICK_CYC(4)) uut (.MCLK_I(clk), .RST_I(rst), .MEAS_BCD_I(meas), .MEAS_NEG_I(neg),
    .MEAS_OVER_I(ovi), .REQ_N_I(req_n), .FREEZE_N_I(frz_n), .BCD_O(bcd), .NEG_O(sgn), .OVER_O(ovr), .VALID_O(vld));
  task chk(input logic [21:0] e, input logic [21:0] a);
    checks_done++;
    if (a !== e) begin
      num_errors++;
      $display("unexpected at %0t: %h not %h", $time, a, e);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wv(input logic v);
    for (n = 0; vld !== v; n++) begin
      if (n > 400) begin
        chk(1, 0);
        finish_test;
      end
      @(negedge clk);
    end
  endtask
  task t_single;
    @(posedge clk) go <= 1;
    @(posedge clk) go <= 0;
    wv(1);
    chk(n > 110 && n < 126, 1);
    wv(0);
    chk(n > 150 && n < 166, 1);
    chk(got, 20'h12345);
    repeat (58) @(negedge clk);
    chk({sgn, ovr, bcd}, {2'b00, 20'h12345});
    repeat (10) @(negedge clk);
    chk(bcd, 0);
    $display("single done");
  endtask
  task t_hold;
    @(posedge clk) go <= 1;
    neg <= 1;
    ovi <= 1;
    wv(1);
    @(posedge clk) frz_n <= 0;
    meas <= 20'h00777;
    repeat (270) @(negedge clk);
    chk({sgn, ovr, bcd}, {2'b11, 20'h12345});
    @(posedge clk) frz_n <= 1;
    repeat (270) @(negedge clk);
    chk({vld, bcd}, {1'b1, 20'h00777});
    $display("hold done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_single;
    t_hold;
    finish_test;
  end
endmodule // bro_port_tb
